// >>> design/mbs_port.sv
// serial follower port: rs-485 character framing, message framing, crc, opcodes
// assumes APB master on pclk, rxd and term_in asynchronous pins, external 485 driver
// Functional notes
// - station address 0..254, zero disables addressed replies
// - baud codes 0..3 select 4800..38400
// - every character is eleven bit times
// - no parity: start, 8 data lsb first, 2 stops
// - even parity: start, 8 data, even, stop
// - odd parity: start, 8 data, odd, stop
// - timeout zero disables, else tenths of seconds
// - timeout warns, then run, ramp or coast
// - terminal source picks pins or link command
// - address 00H broadcast, accepted, never answered
// - addresses 01H..FEH select matching drive only
// - opcodes 03H, 06H, 08H, 10H
// - byte count one byte, words msb first
// - at most eight 16-bit registers per message
// - crc-16 ends message, low byte first, checked
// - fixed request and reply lengths per opcode; 10H requests and 03H replies here vary with the register count
// - read reply: address, opcode, 2n, values, crc
// - crc starts FFFFH, shifts right with A001H
// - error reply: opcode bit7 set, code, crc
// - about five milliseconds before a reply
// - write-single reply echoes the request
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mbs_port #(
	parameter int GAP_CYC = mbs_pkg::GAP_CYC,
	parameter int RESP_CYC = mbs_pkg::RESP_CYC,
	parameter int TICK_CYC = mbs_pkg::TICK_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxd,
	output logic txd,
	output logic tx_en,
	input wire logic [7:0] term_in,
	output logic [7:0] term_out,
	output mbs_pkg::mbs_drv_t drv
);
	mbs_pkg::mbs_state_t s, n;

	// one crc step over a byte
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int k = 0; k < 8; k++) begin
			r = r[0] ? ((r >> 1) ^ mbs_pkg::CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc_byte

	////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		logic [12:0] per;
		logic done, bad_ch, go, bc, ok, lenok, expire;
		logic [9:0] rf;
		logic [7:0] tb;
		logic [15:0] cnt;
		logic [2:0] base;
		n = s;
		per = 13'h0000;
		done = 1'b0;
		bad_ch = 1'b0;
		rf = {s.rxf, s.rsh[9:1]};
		tb = 8'h00;
		cnt = {s.mbuf[4], s.mbuf[5]};
		base = s.mbuf[3][2:0];
		bc = s.mbuf[0] == mbs_pkg::ADDR_BCAST;
		go = 1'b0;
		ok = 1'b0;
		lenok = 1'b0;
		expire = 1'b0;
		// pin synchronisers; a level counts once stages two and three agree
		n.rs = {s.rs[1:0], rxd};
		if (s.rs[1] == s.rs[2]) n.rxf = s.rs[2];
		n.ts1 = term_in;
		n.ts2 = s.ts1;
		n.ts3 = s.ts2;
		if (s.ts2 == s.ts3) n.term = s.ts3;
		// bit period from the rate code
		case (s.cfg.baud)
			2'h0: per = mbs_pkg::BIT0;
			2'h1: per = mbs_pkg::BIT1;
			2'h2: per = mbs_pkg::BIT2;
			default: per = mbs_pkg::BIT3;
		endcase
		// receiver: centre-sample start, 8 data, 2 trailing bits
		if (!s.rbusy) begin
			if (s.st == mbs_pkg::ST_RX && !s.rxf) begin
				n.rbusy = 1'b1;
				n.rdiv = per >> 1;
				n.rbit = 4'h0;
			end
		end else if (s.rdiv != 13'h0000) begin
			n.rdiv = s.rdiv - 13'h0001;
		end else begin
			n.rdiv = per - 13'h0001;
			n.rbit = s.rbit + 4'h1;
			if (s.rbit == 4'h0) begin
				if (s.rxf) n.rbusy = 1'b0; // glitch, not a start bit
			end else begin
				n.rsh = rf;
				if (s.rbit == 4'hA) begin
					n.rbusy = 1'b0;
					done = 1'b1;
				end
			end
		end
		// trailing bits: two stops, or parity then stop
		case (s.cfg.fmt)
			mbs_pkg::FMT_N2: bad_ch = !rf[8] || !rf[9];
			mbs_pkg::FMT_E1: bad_ch = (rf[8] != ^rf[7:0]) || !rf[9];
			default: bad_ch = (rf[8] != ~^rf[7:0]) || !rf[9];
		endcase
		// collect bytes; overflow past 25 bytes spoils the message
		if (done) begin
			if (s.len < mbs_pkg::MAX_LEN) begin
				n.mbuf[s.len] = rf[7:0];
				n.len = s.len + 5'h01;
			end else begin
				n.ferr = 1'b1;
			end
			if (bad_ch) n.ferr = 1'b1;
			n.crc = crc_byte(s.crc, rf[7:0]);
		end
		// link-loss supervision in tenths of a second
		if (s.tmo == 10'h000) begin
			n.tick = 24'h000000;
			n.tenths = 10'h000;
			n.cot = 1'b0;
		end else if (s.tick == 24'(TICK_CYC - 1)) begin
			n.tick = 24'h000000;
			if (s.tenths + 10'h001 >= s.tmo) begin
				n.cot = 1'b1;
				expire = 1'b1;
			end else begin
				n.tenths = s.tenths + 10'h001;
			end
		end else begin
			n.tick = s.tick + 24'h000001;
		end
		// message sequencer
		case (s.st)
			mbs_pkg::ST_RX: begin
				if (s.rbusy || !s.rxf) n.tmr = 24'h000000;
				else if (s.tmr != 24'(GAP_CYC)) n.tmr = s.tmr + 24'h000001;
				if (s.tmr == 24'(GAP_CYC - 1) && s.len != 5'h00) n.st = mbs_pkg::ST_EXEC;
			end
			mbs_pkg::ST_EXEC: begin
				// whole-message crc including its own crc bytes leaves zero
				ok = !s.ferr && s.crc == 16'h0000 && s.len >= 5'h04;
				go = ok && (bc || (s.cfg.station != 8'h00 && s.mbuf[0] == s.cfg.station));
				if (ok && !go) n.good = s.good; // foreign address, quietly dropped
				if (!ok) n.bad = s.bad + 8'h01;
				n.st = mbs_pkg::ST_RX;
				n.tlen = 5'h06;
				if (go) begin
					n.good = s.good + 8'h01;
					n.tick = 24'h000000;
					n.tenths = 10'h000;
					n.cot = expire; // an expiry in this same cycle wins over the restart
					case (s.mbuf[1])
						mbs_pkg::OP_RD: begin
							lenok = s.len == mbs_pkg::FIX_LEN && cnt != 16'h0000 && cnt <= mbs_pkg::MAX_REGS;
							if (lenok) begin
								n.mbuf[2] = {cnt[6:0], 1'b0};
								for (int i = 0; i < 8; i++) begin
									if (16'(i) < cnt) begin
										n.mbuf[3 + 2 * i] = s.mem[3'(base + 3'(i))][15:8];
										n.mbuf[4 + 2 * i] = s.mem[3'(base + 3'(i))][7:0];
									end
								end
								n.tlen = 5'(3 + 2 * int'(cnt[3:0]));
							end
						end
						mbs_pkg::OP_WR1: begin
							lenok = s.len == mbs_pkg::FIX_LEN;
							if (lenok) n.mem[base] = cnt;
						end
						mbs_pkg::OP_DET: begin
							lenok = s.len == mbs_pkg::FIX_LEN;
						end
						mbs_pkg::OP_WRN: begin
							lenok = cnt != 16'h0000 && cnt <= mbs_pkg::MAX_REGS && s.mbuf[6] == {cnt[6:0], 1'b0}
								&& s.len == 5'(9 + 2 * int'(cnt[3:0]));
							if (lenok) begin
								for (int i = 0; i < 8; i++) begin
									if (16'(i) < cnt) n.mem[3'(base + 3'(i))] = {s.mbuf[7 + 2 * i], s.mbuf[8 + 2 * i]};
								end
							end
						end
						default: lenok = 1'b0;
					endcase
					if (!lenok) begin
						n.mbuf[1] = s.mbuf[1] | mbs_pkg::ERR_FLAG;
						n.mbuf[2] = (s.mbuf[1] == mbs_pkg::OP_RD || s.mbuf[1] == mbs_pkg::OP_WR1
							|| s.mbuf[1] == mbs_pkg::OP_DET || s.mbuf[1] == mbs_pkg::OP_WRN)
							? mbs_pkg::ERR_VAL : mbs_pkg::ERR_FUNC;
						n.tlen = 5'h03;
					end
					if (!bc) n.st = mbs_pkg::ST_DLY;
				end
				n.tmr = 24'h000000;
				n.len = 5'h00;
				n.ferr = 1'b0;
				n.crc = mbs_pkg::CRC_INIT;
			end
			mbs_pkg::ST_DLY: begin
				n.tmr = s.tmr + 24'h000001;
				if (s.tmr == 24'(RESP_CYC - 1)) begin
					n.st = mbs_pkg::ST_TX;
					n.tidx = 5'h00;
					n.tbit = 4'h0;
					n.tdiv = 13'h0000;
					n.tcrc = mbs_pkg::CRC_INIT;
					n.txen = 1'b1;
				end
			end
			mbs_pkg::ST_TX: begin
				if (s.tdiv != 13'h0000) begin
					n.tdiv = s.tdiv - 13'h0001;
				end else if (s.tbit != 4'h0) begin
					n.txd = s.tsh[0];
					n.tsh = s.tsh >> 1;
					n.tbit = s.tbit - 4'h1;
					n.tdiv = per - 13'h0001;
				end else if (s.tidx == s.tlen + 5'h02) begin
					n.txen = 1'b0;
					n.txd = 1'b1;
					n.tmr = 24'h000000;
					n.st = mbs_pkg::ST_RX;
				end else begin
					// payload, then crc low byte, then high byte
					if (s.tidx < s.tlen) tb = s.mbuf[s.tidx];
					else if (s.tidx == s.tlen) tb = s.tcrc[7:0];
					else tb = s.tcrc[15:8];
					if (s.tidx < s.tlen) n.tcrc = crc_byte(s.tcrc, tb);
					n.tidx = s.tidx + 5'h01;
					n.txd = 1'b0; // start bit
					case (s.cfg.fmt)
						mbs_pkg::FMT_N2: n.tsh = {2'b11, tb};
						mbs_pkg::FMT_E1: n.tsh = {1'b1, ^tb, tb};
						default: n.tsh = {1'b1, ~^tb, tb};
					endcase
					n.tbit = 4'hA;
					n.tdiv = per - 13'h0001;
				end
			end
			default: n.st = mbs_pkg::ST_RX;
		endcase
		// apb: read data latched in setup, write takes effect in access
		if (psel && !penable) begin
			n.perr = 1'b0;
			case (paddr)
				mbs_pkg::A_CFG: n.prdata = {17'h00000, s.cfg};
				mbs_pkg::A_TMO: n.prdata = {22'h000000, s.tmo};
				mbs_pkg::A_STAT: n.prdata = {s.bad, s.good, 10'h000, s.st, 1'b0, s.cot};
				mbs_pkg::A_CMD: n.prdata = {16'h0000, s.mem[0]};
				default: begin
					n.prdata = 32'h00000000;
					n.perr = 1'b1;
				end
			endcase
		end
		if (psel && penable && pwrite) begin
			if (paddr == mbs_pkg::A_CFG) n.cfg = pwdata[14:0];
			if (paddr == mbs_pkg::A_TMO) n.tmo = pwdata[9:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register; async reset loads constants only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.rs <= 3'h7;
			s.rxf <= 1'b1;
			s.cfg <= mbs_pkg::CFG_RST;
			s.st <= mbs_pkg::ST_RX;
			s.crc <= mbs_pkg::CRC_INIT;
			s.txd <= 1'b1;
		end else begin
			s <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs; pready is always high since read data is ready after setup
	assign prdata = s.prdata;
	assign pready = 1'b1;
	assign pslverr = s.perr;
	assign txd = s.txd;
	assign tx_en = s.txen;
	assign term_out = s.cfg.tsrc ? s.mem[0][7:0] : s.term;
	// one driver for the whole struct: warning, ramp stop, coast stop
	assign drv = {s.cot, s.cot && s.cfg.disp == mbs_pkg::DISP_RAMP, s.cot && s.cfg.disp == mbs_pkg::DISP_COAST};
endmodule : mbs_port
`default_nettype wire

// >>> design/mbs_pkg.sv
// package for the serial follower port: constants, codes and state layout
// assumes a single 20 MHz pclk domain and an APB register bus
package mbs_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int GAP_MS = 10; // idle gap that ends a message
	localparam int RESP_MS = 5; // turnaround before a reply
	localparam int TICK_MS = 100; // timeout unit, 0.1 s
	localparam int GAP_CYC = CLK_HZ / 1000 * GAP_MS;
	localparam int RESP_CYC = CLK_HZ / 1000 * RESP_MS;
	localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam int BPS0 = 4800;
	localparam int BPS1 = 9600;
	localparam int BPS2 = 19200;
	localparam int BPS3 = 38400;
	localparam logic [12:0] BIT0 = 13'((CLK_HZ + BPS0 / 2) / BPS0);
	localparam logic [12:0] BIT1 = 13'((CLK_HZ + BPS1 / 2) / BPS1);
	localparam logic [12:0] BIT2 = 13'((CLK_HZ + BPS2 / 2) / BPS2);
	localparam logic [12:0] BIT3 = 13'((CLK_HZ + BPS3 / 2) / BPS3);
	localparam logic [1:0] FMT_N2 = 2'h0;
	localparam logic [1:0] FMT_E1 = 2'h1;
	localparam logic [1:0] FMT_O1 = 2'h2;
	localparam logic [1:0] DISP_RAMP = 2'h1;
	localparam logic [1:0] DISP_COAST = 2'h2;
	localparam logic [7:0] ADDR_BCAST = 8'h00;
	localparam logic [7:0] OP_RD = 8'h03;
	localparam logic [7:0] OP_WR1 = 8'h06;
	localparam logic [7:0] OP_DET = 8'h08;
	localparam logic [7:0] OP_WRN = 8'h10;
	localparam logic [7:0] ERR_FLAG = 8'h80;
	localparam logic [7:0] ERR_FUNC = 8'h01;
	localparam logic [7:0] ERR_VAL = 8'h03;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;
	localparam logic [4:0] MAX_LEN = 5'h19; // 25 bytes
	localparam logic [4:0] FIX_LEN = 5'h08;
	localparam logic [15:0] MAX_REGS = 16'h0008;
	localparam logic [11:0] A_CFG = 12'h000;
	localparam logic [11:0] A_TMO = 12'h004;
	localparam logic [11:0] A_STAT = 12'h008;
	localparam logic [11:0] A_CMD = 12'h00C;
	typedef struct packed {
		logic tsrc; // bit 14
		logic [1:0] disp; // bits 13:12
		logic [1:0] fmt; // bits 11:10
		logic [1:0] baud; // bits 9:8
		logic [7:0] station; // bits 7:0
	} mbs_cfg_t;
	localparam mbs_cfg_t CFG_RST = 15'h0101; // station 1, 9600
	typedef enum logic [3:0] {ST_RX = 4'b0001, ST_EXEC = 4'b0010, ST_DLY = 4'b0100, ST_TX = 4'b1000} mbs_st_t;
	typedef struct packed {
		logic cot_warn;
		logic stop_ramp;
		logic stop_coast;
	} mbs_drv_t;
	typedef struct packed {
		logic [2:0] rs; logic rxf;
		logic [7:0] ts1, ts2, ts3, term;
		mbs_cfg_t cfg; logic [9:0] tmo;
		mbs_st_t st;
		logic rbusy; logic [12:0] rdiv; logic [3:0] rbit; logic [9:0] rsh;
		logic [4:0] len; logic ferr; logic [15:0] crc; logic [23:0] tmr;
		logic [24:0][7:0] mbuf;
		logic [4:0] tlen, tidx; logic [9:0] tsh; logic [3:0] tbit; logic [12:0] tdiv; logic [15:0] tcrc;
		logic txd, txen;
		logic [7:0][15:0] mem;
		logic [23:0] tick; logic [9:0] tenths; logic cot;
		logic [7:0] good, bad;
		logic [31:0] prdata; logic perr;
	} mbs_state_t;
endpackage : mbs_pkg

// >>> verification/mbs_port_checker.sv
// checker: apb answers, reply framing, drive stop outputs
// assumes only the port's pins; bound below
`timescale 1ns/1ps
`default_nettype none
module mbs_port_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic txd,
	input wire logic tx_en,
	input wire mbs_pkg::mbs_drv_t drv
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	////////////////////////////////
	// a reply frame opens low and closes on the stop level
	sequence s_start_low;
		!txd [*8];
	endsequence
	sequence s_stop_high;
		$past(txd) && txd;
	endsequence
	chk_idle_high: assert property (!tx_en |-> txd)
		else $error("txd low with driver off");
	chk_start_low: assert property ($rose(tx_en) |=> s_start_low)
		else $error("start bit not held low");
	chk_stop_high: assert property ($fell(tx_en) |-> s_stop_high)
		else $error("frame ended off stop level");
	chk_ramp_warn: assert property (drv.stop_ramp |-> drv.cot_warn)
		else $error("ramp stop without warning");
	chk_stop_single: assert property (!(drv.stop_ramp && drv.stop_coast))
		else $error("ramp and coast together");
	chk_ready_high: assert property (psel && penable |-> pready)
		else $error("access without ready");
	chk_unmapped_err: assert property (psel && penable && paddr > 12'h00C |-> pslverr)
		else $error("unmapped access not flagged");
	chk_mapped_ok: assert property (psel && penable && paddr[1:0] == 2'h0 && paddr <= 12'h00C |-> !pslverr)
		else $error("mapped access flagged");
endmodule : mbs_port_checker
bind mbs_port mbs_port_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.paddr(paddr), .pready(pready), .pslverr(pslverr), .txd(txd), .tx_en(tx_en), .drv(drv));
`default_nettype wire

// >>> verification/mbs_host.sv
// host model on the rs-485 line: sends and collects 8N2 characters
// assumes format 0 at bit period BIT; line biased high when idle
`timescale 1ns/1ps
`default_nettype none
module mbs_host #(
	parameter int BIT = 521
) (
	input wire logic pclk,
	input wire logic txd,
	output logic rxd,
	output logic [9:0] rx_word,
	output logic rx_stb
);
	initial begin
		rxd = 1'b1;
		rx_word = 10'h000;
		rx_stb = 1'b0;
	end
	// one character, caller just past an edge; stops leave the line high
	task send(input logic [7:0] b);
		logic [10:0] f;
		f = {2'b11, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rxd <= f[i];
			repeat (BIT) @(posedge pclk);
		end
	endtask : send
	// mid-bit sampling; stop levels land in bits 9:8 so they get checked too
	initial forever begin
		@(negedge txd);
		repeat (BIT / 2) @(posedge pclk);
		for (int i = 0; i < 10; i++) begin
			repeat (BIT) @(posedge pclk);
			rx_word[i] <= txd;
		end
		rx_stb <= 1'b1;
		@(posedge pclk);
		rx_stb <= 1'b0;
	end
endmodule : mbs_host
`default_nettype wire

// >>> verification/modbus_rtu_slave_port_test.sv
// self-checking bench for the serial follower port
// assumes mbs_host on the line, shortened gap, delay and tick counts
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_slave_port_test;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, txd, tx_en, rx_stb, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] term_in, term_out;
	logic [9:0] rx_word;
	logic [9:0] exp_q[$];
	logic [7:0] msg[$];
	logic [15:0] crc;
	mbs_pkg::mbs_drv_t drv;
	int n_mismatch = 0, checked = 0, cyc = 0, seed;
	mbs_port #(.GAP_CYC(6000), .RESP_CYC(500), .TICK_CYC(1000)) DUT (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .tx_en(tx_en), .term_in(term_in),
		.term_out(term_out), .drv(drv));
	mbs_host #(.BIT(521)) u_host (.pclk(pclk), .txd(txd), .rxd(rxd), .rx_word(rx_word), .rx_stb(rx_stb));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	////////////////////////////////
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task report_and_stop;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	// one apb transfer; an idle cycle after keeps psel from being set twice in a step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	function automatic logic [15:0] crc16(input logic [7:0] m[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (m[i]) begin
			c = c ^ {8'h00, m[i]};
			for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction : crc16
	// reply characters arrive on their own time, so they are matched against the queue
	always @(posedge pclk) if (rx_stb) check("reply char", 32'(rx_word), 32'(exp_q.pop_front()));
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 100000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	////////////////////////////////
	initial begin
		seed = 12043;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		term_in = 8'h00;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, mbs_pkg::A_CFG, 32'h0);
		check("cfg reset", rd, 32'h0000_0101);
		apb(1'b0, mbs_pkg::A_TMO, 32'h0);
		check("tmo reset", rd, 32'h0);
		apb(1'b0, 12'h040, 32'h0);
		check("unmapped err", 32'(e), 32'h1);
		repeat (4) begin
			term_in <= 8'($random(seed));
			repeat (6) @(posedge pclk);
			check("pin image", 32'(term_out), 32'(term_in));
		end
		apb(1'b1, mbs_pkg::A_CFG, 32'h0000_4101);
		repeat (2) @(posedge pclk);
		check("link image", 32'(term_out), 32'h0);
		// supervision at one shortened tick of 1000 cycles: silent before, warning after
		apb(1'b1, mbs_pkg::A_TMO, 32'h1);
		repeat (900) @(posedge pclk);
		check("early warn", 32'(drv), 32'h0);
		for (int i = 0; i < 1200 && drv.cot_warn !== 1'b1; i++) @(posedge pclk);
		for (int d = 0; d < 3; d++) begin
			apb(1'b1, mbs_pkg::A_CFG, 32'(32'h0302 | (d << 12)));
			repeat (2) @(posedge pclk);
			check("disposal", 32'(drv), {29'h0, 1'b1, d == 1, d == 2});
		end
		apb(1'b1, mbs_pkg::A_TMO, 32'h0);
		repeat (2) @(posedge pclk);
		check("warn off", 32'(drv), 32'h0);
		// read one register at station 2, 38400 bit/s
		msg = '{8'h02, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
		crc = crc16('{8'h02, 8'h03, 8'h02, 8'h00, 8'h00});
		exp_q = '{10'h302, 10'h303, 10'h302, 10'h300, 10'h300, {2'b11, crc[7:0]}, {2'b11, crc[15:8]}};
		crc = crc16(msg);
		msg.push_back(crc[7:0]);
		msg.push_back(crc[15:8]);
		foreach (msg[i]) u_host.send(msg[i]);
		for (int i = 0; i < 60000 && exp_q.size() > 0; i++) @(posedge pclk);
		check("reply left", 32'(exp_q.size()), 32'h0);
		// let the last stop bit finish, then one good message, none bad, back in receive
		repeat (300) @(posedge pclk);
		apb(1'b0, mbs_pkg::A_STAT, 32'h0);
		check("status", rd, 32'h0001_0004);
		report_and_stop();
	end
endmodule : modbus_rtu_slave_port_test
`default_nettype wire
